// ==== inc/tcm_map.svh ====
// Register addresses, field positions and reset values of the timer channel mode block
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

`define TCM_T1_MODE_ONE_ADR 32'h4000E018
`define TCM_T1_MODE_TWO_ADR 32'h4000E01C
`define TCM_T1_CHAN_ON_ADR 32'h4000E020
`define TCM_T1_SLAVE_ADR 32'h4000E008
`define TCM_T2_MODE_ONE_ADR 32'h4000F018
`define TCM_T2_MODE_TWO_ADR 32'h4000F01C
`define TCM_T2_CHAN_ON_ADR 32'h4000F020
`define TCM_T2_SLAVE_ADR 32'h4000F008

`define TCM_MODE_RST 16'h0000
`define TCM_MODE_WMASK 16'h7F7F
`define TCM_CHAN_ON_RST 4'h0
`define TCM_TSEL_RST 3'h0

`define TCM_DIR_LSB 0
`define TCM_PSC_LSB 2
`define TCM_FAST_BIT 2
`define TCM_BUF_BIT 3
`define TCM_BEH_LSB 4
`define TCM_ON_STRIDE 4
`define TCM_TSEL_LSB 4

`endif

// ==== inc/tcm_pkg.sv ====
// Types shared by the timer channel mode block
package tcm_pkg;

  typedef enum logic [1:0] {
    TCM_DIR_OUT = 2'b00,
    TCM_DIR_IN_A = 2'b01,
    TCM_DIR_IN_B = 2'b10,
    TCM_DIR_IN_TRG = 2'b11
  } tcm_dir_t;

  typedef enum logic [2:0] {
    TCM_REG_NONE = 3'b000,
    TCM_REG_MODE_ONE = 3'b001,
    TCM_REG_MODE_TWO = 3'b010,
    TCM_REG_CHAN_ON = 3'b011,
    TCM_REG_SLAVE = 3'b100
  } tcm_reg_t;

endpackage : tcm_pkg

// ==== rtl/tcm_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module tcm_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage_one <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end

endmodule : tcm_sync

`default_nettype wire

// ==== rtl/tcm_chan_sel.sv ====
// Direction and source selection of one capture/compare channel
`timescale 1ns/1ps
`default_nettype none

`include "tcm_map.svh"

module tcm_chan_sel
  import tcm_pkg::*;
#(
  parameter bit SWAP = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Channel configuration, low seven bits of the channel byte
  input wire logic [6:0] cfg_i,
  // Capture sources
  input wire logic ti_one_i,
  input wire logic ti_two_i,
  input wire logic trig_i,
  // Effective channel settings
  output logic is_output_o,
  output logic capture_o,
  output logic [2:0] behaviour_o,
  output logic buffer_on_o,
  output logic fast_on_o,
  output logic [2:0] filter_o,
  output logic [1:0] prescale_o
);

  tcm_dir_t dir;
  logic out_mode;

  assign dir = tcm_dir_t'(cfg_i[`TCM_DIR_LSB +: 2]);
  assign out_mode = (dir == TCM_DIR_OUT);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      is_output_o <= 1'b1;
      capture_o <= 1'b0;
    end
    else
    begin
      is_output_o <= out_mode;
      case (dir)
        TCM_DIR_IN_A: capture_o <= SWAP ? ti_two_i : ti_one_i;
        TCM_DIR_IN_B: capture_o <= SWAP ? ti_one_i : ti_two_i;
        TCM_DIR_IN_TRG: capture_o <= trig_i;
        default: capture_o <= 1'b0;
      endcase
    end
  end

  // Compare fields only for outputs, capture fields only for inputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      behaviour_o <= 3'h0;
      buffer_on_o <= 1'b0;
      fast_on_o <= 1'b0;
      filter_o <= 3'h0;
      prescale_o <= 2'h0;
    end
    else
    begin
      behaviour_o <= out_mode ? cfg_i[`TCM_BEH_LSB +: 3] : 3'h0;
      buffer_on_o <= out_mode & cfg_i[`TCM_BUF_BIT];
      fast_on_o <= out_mode & cfg_i[`TCM_FAST_BIT];
      filter_o <= out_mode ? 3'h0 : cfg_i[`TCM_BEH_LSB +: 3];
      prescale_o <= out_mode ? 2'h0 : cfg_i[`TCM_PSC_LSB +: 2];
    end
  end

endmodule : tcm_chan_sel

`default_nettype wire

// ==== rtl/tcm_top.sv ====
// Channel mode registers and channel direction selection for two timers
//
// Overview of operation
// - Selection 00 makes the channel a compare output.
// - Selection 01 on channel one captures from the first timer input.
// - Selection 10 on channel one captures from the second timer input.
// - Selection 11 captures from the internal trigger, chosen by trigger select.
// - Mode register two: ch4 bits 11,10,9:8; ch3 bits 3,2,1:0.
// - Mode register two of each timer at its fixed address, reset zero.
// - Each channel direction comes only from its own selection field.
// - Compare mode, buffer and fast fields act only when selection is zero.
// - Capture filter and prescaler act only when selection is nonzero.
// - Channel one prescaler sits in bits 3:2 of mode register one, read/write.
`timescale 1ns/1ps
`default_nettype none

`include "tcm_map.svh"

module tcm_top
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer input pins, one bit per timer
  input wire logic [1:0] timer_input_one_i,
  input wire logic [1:0] timer_input_two_i,
  // Internal trigger candidates, eight per timer
  input wire logic [15:0] trig_cand_i,
  // Selected internal trigger per timer
  output logic [1:0] internal_trigger_in_o,
  // Per channel state, four channels per timer
  output logic [7:0] chan_is_output_o,
  output logic [7:0] chan_capture_o,
  output logic [23:0] chan_compare_behaviour_o,
  output logic [7:0] chan_compare_buffer_on_o,
  output logic [7:0] chan_compare_fast_on_o,
  output logic [23:0] chan_capture_filter_o,
  output logic [15:0] chan_capture_prescale_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  logic [15:0] mode_reg [0:1][0:1];
  logic [3:0] chan_on [0:1];
  logic [2:0] trigger_source_select [0:1];

  logic [1:0] ti_one_s;
  logic [1:0] ti_two_s;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  tcm_reg_t reg_sel;
  logic hit_t;
  logic req;
  logic wr;

  always_comb
  begin
    reg_sel = TCM_REG_NONE;
    hit_t = 1'b0;
    if (wb_adr_i == `TCM_T1_MODE_ONE_ADR)
    begin
      reg_sel = TCM_REG_MODE_ONE;
    end
    else if (wb_adr_i == `TCM_T1_MODE_TWO_ADR)
    begin
      reg_sel = TCM_REG_MODE_TWO;
    end
    else if (wb_adr_i == `TCM_T1_CHAN_ON_ADR)
    begin
      reg_sel = TCM_REG_CHAN_ON;
    end
    else if (wb_adr_i == `TCM_T1_SLAVE_ADR)
    begin
      reg_sel = TCM_REG_SLAVE;
    end
    else if (wb_adr_i == `TCM_T2_MODE_ONE_ADR)
    begin
      reg_sel = TCM_REG_MODE_ONE;
      hit_t = 1'b1;
    end
    else if (wb_adr_i == `TCM_T2_MODE_TWO_ADR)
    begin
      reg_sel = TCM_REG_MODE_TWO;
      hit_t = 1'b1;
    end
    else if (wb_adr_i == `TCM_T2_CHAN_ON_ADR)
    begin
      reg_sel = TCM_REG_CHAN_ON;
      hit_t = 1'b1;
    end
    else if (wb_adr_i == `TCM_T2_SLAVE_ADR)
    begin
      reg_sel = TCM_REG_SLAVE;
      hit_t = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------

  // Request seen while no ack is out; write lands at the acked edge
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
    end
  end

  // ----------------------------------------------------------------
  // Write merge for a channel mode register
  // ----------------------------------------------------------------

  // Byte lanes select channels; a channel that is on keeps its direction
  function automatic logic [15:0] merge_mode(
    input logic [15:0] old,
    input logic [15:0] dat,
    input logic [1:0] sel,
    input logic [1:0] on
  );
    logic [15:0] res;
    res = old;
    for (int b = 0; b < 2; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = dat[b*8 +: 8];
        if (on[b])
        begin
          res[b*8 +: 2] = old[b*8 +: 2];
        end
      end
    end
    return res & `TCM_MODE_WMASK;
  endfunction : merge_mode

  // ----------------------------------------------------------------
  // Registers per timer
  // ----------------------------------------------------------------

  genvar t;
  genvar r;
  generate
    for (t = 0; t < 2; t++)
    begin : g_timer
      logic hit;
      assign hit = (hit_t == 1'(t));

      for (r = 0; r < 2; r++)
      begin : g_mode
        logic sel_this;
        assign sel_this = hit &
          (reg_sel == ((r == 0) ? TCM_REG_MODE_ONE : TCM_REG_MODE_TWO));

        always_ff @(posedge clk_i)
        begin
          if (rst_i)
          begin
            mode_reg[t][r] <= `TCM_MODE_RST;
          end
          else if (wr && sel_this)
          begin
            mode_reg[t][r] <= merge_mode(mode_reg[t][r], wb_dat_i[15:0],
              wb_sel_i[1:0], chan_on[t][r*2 +: 2]);
          end
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          chan_on[t] <= `TCM_CHAN_ON_RST;
        end
        else if (wr && hit && reg_sel == TCM_REG_CHAN_ON)
        begin
          for (int c = 0; c < 4; c++)
          begin
            if (wb_sel_i[c/2])
            begin
              chan_on[t][c] <= wb_dat_i[c*`TCM_ON_STRIDE];
            end
          end
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          trigger_source_select[t] <= `TCM_TSEL_RST;
        end
        else if (wr && hit && reg_sel == TCM_REG_SLAVE && wb_sel_i[0])
        begin
          trigger_source_select[t] <= wb_dat_i[`TCM_TSEL_LSB +: 3];
        end
      end

      // Internal trigger picked by the trigger source select
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          internal_trigger_in_o[t] <= 1'b0;
        end
        else
        begin
          internal_trigger_in_o[t] <=
            trig_cand_i[t*8 + int'(trigger_source_select[t])];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (req && !wb_we_i)
    begin
      case (reg_sel)
        TCM_REG_MODE_ONE: wb_dat_o <= {16'h0000, mode_reg[hit_t][0]};
        TCM_REG_MODE_TWO: wb_dat_o <= {16'h0000, mode_reg[hit_t][1]};
        TCM_REG_CHAN_ON:
          wb_dat_o <= {19'h0, chan_on[hit_t][3], 3'h0, chan_on[hit_t][2],
            3'h0, chan_on[hit_t][1], 3'h0, chan_on[hit_t][0]};
        TCM_REG_SLAVE: wb_dat_o <= {25'h0, trigger_source_select[hit_t], 4'h0};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  tcm_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({timer_input_two_i, timer_input_one_i}),
    .sync_o({ti_two_s, ti_one_s})
  );

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------

  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_chan
      // Even channels map 01 to input one, odd channels to input two
      tcm_chan_sel #(
        .SWAP(k % 2 == 1)
      ) u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(mode_reg[k/4][(k%4)/2][(k%2)*8 +: 7]),
        .ti_one_i(ti_one_s[k/4]),
        .ti_two_i(ti_two_s[k/4]),
        .trig_i(internal_trigger_in_o[k/4]),
        .is_output_o(chan_is_output_o[k]),
        .capture_o(chan_capture_o[k]),
        .behaviour_o(chan_compare_behaviour_o[k*3 +: 3]),
        .buffer_on_o(chan_compare_buffer_on_o[k]),
        .fast_on_o(chan_compare_fast_on_o[k]),
        .filter_o(chan_capture_filter_o[k*3 +: 3]),
        .prescale_o(chan_capture_prescale_o[k*2 +: 2])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [1:0] dir_c1;
  logic [1:0] dir_c2;
  assign dir_c1 = mode_reg[0][0][1:0];
  assign dir_c2 = mode_reg[0][0][9:8];

  sequence s_read_t2_two;
    req && !wb_we_i && wb_adr_i == `TCM_T2_MODE_TWO_ADR;
  endsequence

  sequence s_write_t1_two;
    wr && wb_adr_i == `TCM_T1_MODE_TWO_ADR && wb_sel_i == 4'hF
      && chan_on[0][3:2] == 2'h0;
  endsequence

  property p_out_sel;
    dir_c1 == 2'h0 |=> chan_is_output_o[0];
  endproperty
  a_out_sel: assert property (p_out_sel) else $error("output select lost");

  property p_in_one;
    dir_c1 == 2'h1 |=> chan_capture_o[0] == $past(ti_one_s[0]) && !chan_is_output_o[0];
  endproperty
  a_in_one: assert property (p_in_one) else $error("input one not routed");

  property p_in_two;
    dir_c1 == 2'h2 |=> chan_capture_o[0] == $past(ti_two_s[0]);
  endproperty
  a_in_two: assert property (p_in_two) else $error("input two not routed");

  property p_in_trg;
    dir_c1 == 2'h3 |=> chan_capture_o[0] == $past(internal_trigger_in_o[0]);
  endproperty
  a_in_trg: assert property (p_in_trg) else $error("trigger not routed");

  property p_two_layout;
    s_write_t1_two |=> mode_reg[0][1] == ($past(wb_dat_i[15:0]) & 16'h7F7F);
  endproperty
  a_two_layout: assert property (p_two_layout) else $error("mode two layout");

  property p_two_read;
    s_read_t2_two ##1 1'b1 |-> wb_ack_o && wb_dat_o == {16'h0000, $past(mode_reg[1][1])};
  endproperty
  a_two_read: assert property (p_two_read) else $error("timer two readback");

  property p_own_field;
    dir_c2 == 2'h0 && dir_c1 != 2'h0 |=> chan_is_output_o[1] && !chan_is_output_o[0];
  endproperty
  a_own_field: assert property (p_own_field) else $error("direction mixed");

  property p_cmp_gate;
    dir_c1 != 2'h0 |=> chan_compare_behaviour_o[2:0] == 3'h0
      && !chan_compare_buffer_on_o[0] && !chan_compare_fast_on_o[0];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare leaks");

  property p_cap_gate;
    dir_c1 == 2'h0 |=> chan_capture_filter_o[2:0] == 3'h0
      && chan_capture_prescale_o[1:0] == 2'h0;
  endproperty
  a_cap_gate: assert property (p_cap_gate) else $error("capture leaks");

  property p_psc_rw;
    wr && wb_adr_i == `TCM_T1_MODE_ONE_ADR && wb_sel_i[0]
      |=> mode_reg[0][0][3:2] == $past(wb_dat_i[3:2]);
  endproperty
  a_psc_rw: assert property (p_psc_rw) else $error("prescale not stored");

  property p_zero_bits;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 && !mode_reg[0][1][15] && !mode_reg[1][1][7];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");

endmodule : tcm_top

`default_nettype wire

// ==== sim/timer_channel_mode_select_tb.sv ====
// Self-checking testbench for the timer channel mode block
`timescale 1ns/1ps
`default_nettype none

`include "tcm_map.svh"

module timer_channel_mode_select_tb;

  // ----------------------------------------
  // Clock, reset and design signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [31:0] wb_adr = 32'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] pin_one = 2'h0;
  logic [1:0] pin_two = 2'h0;
  logic [15:0] trig_cand = 16'h0;
  logic [1:0] internal_trigger_in_o;
  logic [7:0] chan_is_output_o;
  logic [7:0] chan_capture_o;
  logic [23:0] chan_compare_behaviour_o;
  logic [7:0] chan_compare_buffer_on_o;
  logic [7:0] chan_compare_fast_on_o;
  logic [23:0] chan_capture_filter_o;
  logic [15:0] chan_capture_prescale_o;
  logic [31:0] rd;
  logic cap_exp;
  int n_errors = 0;
  int compares = 0;

  always #2.5 clk_i = ~clk_i;

  tcm_top uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wdat),
    .wb_sel_i(wb_sel),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .timer_input_one_i(pin_one),
    .timer_input_two_i(pin_two),
    .trig_cand_i(trig_cand),
    .internal_trigger_in_o(internal_trigger_in_o),
    .chan_is_output_o(chan_is_output_o),
    .chan_capture_o(chan_capture_o),
    .chan_compare_behaviour_o(chan_compare_behaviour_o),
    .chan_compare_buffer_on_o(chan_compare_buffer_on_o),
    .chan_compare_fast_on_o(chan_compare_fast_on_o),
    .chan_capture_filter_o(chan_capture_filter_o),
    .chan_capture_prescale_o(chan_capture_prescale_o)
  );

  // ----------------------------------------
  // Report and compare tasks
  // ----------------------------------------
  task automatic conclude();
    $display("Checks: %0d, mismatches: %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg

  task automatic chk_out(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_out

  // ----------------------------------------
  // Wishbone classic master
  // ----------------------------------------
  task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                         output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      $display("BAD ack expected 1 seen timeout");
      conclude();
    end
  endtask : wb_xfer

  task automatic wb_write(input logic [31:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, dat, unused);
  endtask : wb_write

  task automatic wb_read(input logic [31:0] adr, output logic [31:0] rdat);
    wb_xfer(1'b0, adr, 32'h0, rdat);
  endtask : wb_read

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(2);
    wb_read(`TCM_T1_MODE_TWO_ADR, rd);
    chk_reg("t1_mode_two", 32'h0, rd);
    wb_read(`TCM_T2_MODE_TWO_ADR, rd);
    chk_reg("t2_mode_two", 32'h0, rd);
    chk_out("is_output", 32'hFF, {24'h0, chan_is_output_o});
    // Unused bits stay zero, channel 3 and 4 fields land in place
    wb_write(`TCM_T1_MODE_TWO_ADR, 32'hFFFFFFFF);
    wb_read(`TCM_T1_MODE_TWO_ADR, rd);
    chk_reg("t1_mode_two", 32'h00007F7F, rd);
    settle(3);
    chk_out("is_output", 32'hF3, {24'h0, chan_is_output_o});
    chk_out("ch3_filter", 32'h7, {29'h0, chan_capture_filter_o[8:6]});
    wb_write(`TCM_T1_MODE_TWO_ADR, 32'h00000000);
    // Trigger select 3 for timer one
    wb_write(`TCM_T1_SLAVE_ADR, 32'h00000030);
    wb_read(`TCM_T1_SLAVE_ADR, rd);
    chk_reg("t1_slave", 32'h00000030, rd);
    // Every selection code on channel one
    for (int d = 0; d < 4; d++)
    begin
      wb_write(`TCM_T1_MODE_ONE_ADR, 32'h5C | 32'(d));
      wb_read(`TCM_T1_MODE_ONE_ADR, rd);
      chk_reg("t1_mode_one", 32'h5C | 32'(d), rd);
      for (int p = 0; p < 2; p++)
      begin
        @(posedge clk_i);
        pin_one <= {1'b0, p == 0};
        pin_two <= {1'b0, p == 1};
        trig_cand <= {12'h0, p == 1, 3'h0};
        settle(5);
        cap_exp = (d == 1) ? (p == 0) : (d == 2) ? (p == 1) : (d == 3) ? (p == 1) : 1'b0;
        chk_out("capture", {31'h0, cap_exp}, {31'h0, chan_capture_o[0]});
        chk_out("trigger", 32'(p), {31'h0, internal_trigger_in_o[0]});
      end
      chk_out("is_output", {31'h0, d == 0}, {31'h0, chan_is_output_o[0]});
      chk_out("behaviour", (d == 0) ? 32'h5 : 32'h0, {29'h0, chan_compare_behaviour_o[2:0]});
      chk_out("buffer_on", {31'h0, d == 0}, {31'h0, chan_compare_buffer_on_o[0]});
      chk_out("fast_on", {31'h0, d == 0}, {31'h0, chan_compare_fast_on_o[0]});
      chk_out("filter", (d == 0) ? 32'h0 : 32'h5, {29'h0, chan_capture_filter_o[2:0]});
      chk_out("prescale", (d == 0) ? 32'h0 : 32'h3, {30'h0, chan_capture_prescale_o[1:0]});
    end
    // Selection held while channel one is switched on
    wb_write(`TCM_T1_CHAN_ON_ADR, 32'h00000001);
    wb_read(`TCM_T1_CHAN_ON_ADR, rd);
    chk_reg("t1_chan_on", 32'h00000001, rd);
    wb_write(`TCM_T1_MODE_ONE_ADR, 32'h00000000);
    wb_read(`TCM_T1_MODE_ONE_ADR, rd);
    chk_reg("t1_mode_one", 32'h00000003, rd);
    settle(2);
    chk_out("is_output", 32'h0, {31'h0, chan_is_output_o[0]});
    wb_write(`TCM_T1_CHAN_ON_ADR, 32'h00000000);
    wb_write(`TCM_T1_MODE_ONE_ADR, 32'h00000000);
    wb_read(`TCM_T1_MODE_ONE_ADR, rd);
    chk_reg("t1_mode_one", 32'h0, rd);
    // Timer two channel four as input, others untouched
    wb_write(`TCM_T2_MODE_TWO_ADR, 32'h00000100);
    wb_read(`TCM_T2_MODE_TWO_ADR, rd);
    chk_reg("t2_mode_two", 32'h00000100, rd);
    wb_read(`TCM_T1_MODE_TWO_ADR, rd);
    chk_reg("t1_mode_two", 32'h0, rd);
    settle(2);
    chk_out("is_output", 32'h7F, {24'h0, chan_is_output_o});
    // Channel four of timer two maps 01 to the second input
    @(posedge clk_i);
    pin_two <= 2'b10;
    settle(5);
    chk_out("t2_ch4_capture", 32'h1, {31'h0, chan_capture_o[7]});
    chk_out("t2_ch4_filter", 32'h0, {29'h0, chan_capture_filter_o[23:21]});
    chk_out("t2_ch4_behaviour", 32'h0, {29'h0, chan_compare_behaviour_o[23:21]});
    // Unmapped place reads zero
    wb_write(32'h4000E030, 32'hFFFFFFFF);
    wb_read(32'h4000E030, rd);
    chk_reg("unmapped", 32'h0, rd);
    conclude();
  end

endmodule : timer_channel_mode_select_tb

`default_nettype wire
